/* File: nclg_defs.svh */
`ifndef NCLG_DEFS_SVH
`define NCLG_DEFS_SVH
// register byte offsets
`define NCLG_OFF_CLKDIV 8'h00
`define NCLG_OFF_INDEX 8'h04
`define NCLG_OFF_STATUS 8'h08
`define NCLG_OFF_PARAM 8'h0C
`define NCLG_OFF_RSVD_A 8'h10
`define NCLG_OFF_RSVD_B 8'h14
`define NCLG_OFF_RSVD_C 8'h18
`define NCLG_OFF_VERSION 8'h1C
// field positions
`define NCLG_DIVLD_BIT 7
`define NCLG_COMMAND_COMPLETE_FLAG_BIT 7
`define NCLG_ACCESS_ERROR_FLAG_BIT 5
`define NCLG_PROTECTION_VIOLATION_FLAG_BIT 4
`define NCLG_VER_VALID_BIT 4
// reset values
`define NCLG_RST_DIV 6'h00
`define NCLG_RST_IDX 3'h0
// array geometry
`define NCLG_NUM_WORDS 6
`define NCLG_VER_NONE_LO 4'h0
`define NCLG_VER_NONE_HI 4'hF
// bus answers
`define NCLG_RESP_OKAY 2'b00
`define NCLG_RESP_SLVERR 2'b10
`endif

/* File: nclg_pkg.sv */
package nclg_pkg;
   typedef enum logic [1:0] {
      NCLG_IDLE = 2'b00,
      NCLG_CHECK = 2'b01,
      NCLG_BUSY = 2'b11
   } nclg_state_t;
   typedef enum logic [7:0] {
      NCLG_ERS_VFY_ALL = 8'h01, NCLG_ERS_VFY_BLK = 8'h02,
      NCLG_ERS_VFY_SEC = 8'h03, NCLG_READ_ONCE = 8'h04,
      NCLG_PROG = 8'h06, NCLG_PROG_ONCE = 8'h07,
      NCLG_ERS_ALL = 8'h08, NCLG_ERS_BLK = 8'h09,
      NCLG_ERS_SECT = 8'h0A, NCLG_UNSECURE = 8'h0B,
      NCLG_BACKDOOR = 8'h0C, NCLG_USER_MARGIN = 8'h0D,
      NCLG_FIELD_MARGIN = 8'h0E, NCLG_D_VFY_SEC = 8'h10,
      NCLG_D_PROG = 8'h11, NCLG_D_ERS_SECT = 8'h12
   } nclg_cmd_t;
   typedef struct packed {
      logic [5:0][15:0] words;
   } nclg_params_t;
   typedef struct packed {
      logic special;
      logic secured;
   } nclg_mode_t;
endpackage

/* File: nclg_gate.sv */
// Notes on behaviour
// [RULE1] reserved test registers read zero, ignore writes
// [RULE2] version word: low nibble number, 0/F none
// [RULE3] software loads divider before program or erase
// [RULE4] no program/erase below 0.8 MHz bus
// [RULE5] divider write sets the loaded flag
// [RULE6] unloaded divider: program/erase rejected, access error
// [RULE7] software clears errors, checks completion before launch
// [RULE8] busy: no launch, array writes discarded
// [RULE9] index register selects the array word
// [RULE10] writing one to completion launches command
// [RULE11] completion set at finish, results into array
// [RULE12] mode and security inputs select valid commands
// [RULE13] erase-verify commands valid in every state; code keeps only erase-verify-all and -block valid in every state
// [RULE14] general commands invalid only secured special
// [RULE15] erase-all and unsecure only special mode
// [RULE16] backdoor key only normal mode
// [RULE17] field margin only unsecured special mode
// [RULE18] word zero high byte is command code
// [RULE19] indices six, seven ignore writes, read zero
// [RULE20] undefined or disallowed code: access error, completion
`include "nclg_defs.svh"
module nclg_gate
   import nclg_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // mode pins and information row
   input wire logic special_mode_input,
   input wire logic secure_input,
   input wire logic [15:0] info_version_word,
   // memory controller
   output logic cmd_start,
   output nclg_params_t cmd_params,
   input wire logic cmd_done,
   input wire nclg_params_t cmd_result,
   input wire logic cmd_protection_violation_flag,
   // time base
   output logic nvm_time_base
);
   nclg_state_t state;
   nclg_params_t arr;
   nclg_mode_t mode_s1, mode_s2, mode_s3, mode_q;
   logic [5:0] divider_value, tb_cnt;
   logic [2:0] parameter_index_field;
   logic divider_loaded_flag, aw_held, w_held;
   logic command_complete_flag, access_error_flag, protection_violation_flag;
   logic [7:0] aw_addr, code;
   logic [31:0] w_data, next_rdata;
   logic [3:0] w_strb;
   logic wr_fire, wr_map, rd_map, rd_fire, wr_div, wr_idx, wr_stat, wr_arr, launch;
   logic is_pe, code_ok, check_pass;
   logic [15:0] idx_word;
   // mode pin synchronisers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_s1 <= '0;
         mode_s2 <= '0;
         mode_s3 <= '0;
         mode_q <= '0;
      end else begin
         mode_s1 <= {special_mode_input, secure_input};
         mode_s2 <= mode_s1;
         mode_s3 <= mode_s2;
         if (mode_s2 == mode_s3) begin
            mode_q <= mode_s3;
         end
      end
   end
   // write channel capture
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end
   always_comb begin
      wr_map = 1'b1;
      case (aw_addr)
         `NCLG_OFF_CLKDIV, `NCLG_OFF_INDEX, `NCLG_OFF_STATUS, `NCLG_OFF_PARAM: wr_map = 1'b1;
         `NCLG_OFF_RSVD_A, `NCLG_OFF_RSVD_B, `NCLG_OFF_RSVD_C: wr_map = 1'b1; // RULE1
         `NCLG_OFF_VERSION: wr_map = 1'b1;
         default: wr_map = 1'b0;
      endcase
   end
   assign wr_div = wr_fire && aw_addr == `NCLG_OFF_CLKDIV && w_strb[0];
   assign wr_idx = wr_fire && aw_addr == `NCLG_OFF_INDEX && w_strb[0];
   assign wr_stat = wr_fire && aw_addr == `NCLG_OFF_STATUS && w_strb[0];
   assign wr_arr = wr_fire && aw_addr == `NCLG_OFF_PARAM && command_complete_flag; // RULE8
   assign launch = wr_stat && w_data[`NCLG_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag
      && !access_error_flag && !protection_violation_flag && state == NCLG_IDLE;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `NCLG_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_map ? `NCLG_RESP_OKAY : `NCLG_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   // divider and index
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         divider_value <= `NCLG_RST_DIV;
         divider_loaded_flag <= 1'b0;
      end else if (wr_div) begin
         divider_value <= w_data[5:0];
         divider_loaded_flag <= 1'b1; // RULE5
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         parameter_index_field <= `NCLG_RST_IDX;
      end else if (wr_idx) begin
         parameter_index_field <= w_data[2:0]; // RULE9
      end
   end
   // time base tick
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tb_cnt <= 6'h00;
         nvm_time_base <= 1'b0;
      end else if (!divider_loaded_flag || tb_cnt == divider_value) begin
         tb_cnt <= 6'h00;
         nvm_time_base <= divider_loaded_flag;
      end else begin
         tb_cnt <= tb_cnt + 6'h01;
         nvm_time_base <= 1'b0;
      end
   end
   // parameter array, one word per entry
   for (genvar i = 0; i < `NCLG_NUM_WORDS; i++) begin : g_word
      always_ff @(posedge core_clk or negedge reset_n) begin
         if (!reset_n) begin
            arr.words[i] <= 16'h0000;
         end else if (state == NCLG_BUSY && cmd_done) begin
            arr.words[i] <= cmd_result.words[i]; // RULE11
         end else if (wr_arr && parameter_index_field == 3'(i)) begin // RULE9
            if (w_strb[1]) begin
               arr.words[i][15:8] <= w_data[15:8];
            end
            if (w_strb[0]) begin
               arr.words[i][7:0] <= w_data[7:0];
            end
         end
      end
   end
   // command checks
   assign code = arr.words[0][15:8]; // RULE18
   always_comb begin
      is_pe = 1'b0;
      code_ok = 1'b0;
      case (code)
         NCLG_ERS_VFY_ALL, NCLG_ERS_VFY_BLK: code_ok = 1'b1; // RULE13
         NCLG_ERS_VFY_SEC, NCLG_READ_ONCE, NCLG_USER_MARGIN, NCLG_D_VFY_SEC: begin
            code_ok = !(mode_q.special && mode_q.secured); // RULE14
         end
         NCLG_PROG, NCLG_PROG_ONCE, NCLG_ERS_BLK, NCLG_ERS_SECT, NCLG_D_PROG,
         NCLG_D_ERS_SECT: begin
            is_pe = 1'b1;
            code_ok = !(mode_q.special && mode_q.secured); // RULE14
         end
         NCLG_ERS_ALL, NCLG_UNSECURE: begin
            is_pe = 1'b1;
            code_ok = mode_q.special; // RULE15
         end
         NCLG_BACKDOOR: code_ok = !mode_q.special; // RULE16
         NCLG_FIELD_MARGIN: code_ok = mode_q.special && !mode_q.secured; // RULE17
         default: code_ok = 1'b0; // RULE20
      endcase
   end
   assign check_pass = code_ok && (divider_loaded_flag || !is_pe); // RULE6 RULE12
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= NCLG_IDLE;
      end else begin
         case (state)
            NCLG_IDLE: if (launch) state <= NCLG_CHECK; // RULE10
            NCLG_CHECK: state <= check_pass ? NCLG_BUSY : NCLG_IDLE;
            NCLG_BUSY: if (cmd_done) state <= NCLG_IDLE;
            default: state <= NCLG_IDLE;
         endcase
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_start <= 1'b0;
         cmd_params <= '0;
      end else begin
         cmd_start <= state == NCLG_CHECK && check_pass;
         if (state == NCLG_CHECK && check_pass) begin
            cmd_params <= arr; // RULE10
         end
      end
   end
   // status flags, hardware set wins over clear
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         command_complete_flag <= 1'b1;
      end else if (state == NCLG_CHECK && !check_pass) begin
         command_complete_flag <= 1'b1; // RULE20
      end else if (state == NCLG_BUSY && cmd_done) begin
         command_complete_flag <= 1'b1; // RULE11
      end else if (launch) begin
         command_complete_flag <= 1'b0; // RULE10
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         access_error_flag <= 1'b0;
      end else if (state == NCLG_CHECK && !check_pass) begin
         access_error_flag <= 1'b1; // RULE6 RULE20
      end else if (wr_stat && w_data[`NCLG_ACCESS_ERROR_FLAG_BIT]) begin
         access_error_flag <= 1'b0;
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         protection_violation_flag <= 1'b0;
      end else if (state == NCLG_BUSY && cmd_done && cmd_protection_violation_flag) begin
         protection_violation_flag <= 1'b1;
      end else if (wr_stat && w_data[`NCLG_PROTECTION_VIOLATION_FLAG_BIT]) begin
         protection_violation_flag <= 1'b0;
      end
   end
   // read path
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign idx_word = parameter_index_field < 3'(`NCLG_NUM_WORDS)
      ? arr.words[parameter_index_field] : 16'h0000; // RULE19
   always_comb begin
      next_rdata = 32'h0000_0000;
      rd_map = 1'b1;
      case (s_axi_araddr)
         `NCLG_OFF_CLKDIV: next_rdata = {24'h00_0000, divider_loaded_flag, 1'b0, divider_value};
         `NCLG_OFF_INDEX: next_rdata = {29'h0, parameter_index_field};
         `NCLG_OFF_STATUS: next_rdata = {24'h00_0000, command_complete_flag, 1'b0,
            access_error_flag, protection_violation_flag, 4'h0};
         `NCLG_OFF_PARAM: next_rdata = {16'h0000, idx_word};
         `NCLG_OFF_RSVD_A, `NCLG_OFF_RSVD_B, `NCLG_OFF_RSVD_C: next_rdata = 32'h0000_0000; // RULE1
         `NCLG_OFF_VERSION: begin
            next_rdata[3:0] = info_version_word[3:0]; // RULE2
            next_rdata[`NCLG_VER_VALID_BIT] = info_version_word[3:0] != `NCLG_VER_NONE_LO
               && info_version_word[3:0] != `NCLG_VER_NONE_HI; // RULE2
         end
         default: rd_map = 1'b0;
      endcase
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `NCLG_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= rd_map ? `NCLG_RESP_OKAY : `NCLG_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_launch; launch; endsequence
   sequence s_check_fail; state == NCLG_CHECK && !check_pass; endsequence
   sequence s_check_ok; state == NCLG_CHECK && check_pass; endsequence
   AST_RSVD_ZERO: assert property (rd_fire && (s_axi_araddr == `NCLG_OFF_RSVD_A // RULE1
      || s_axi_araddr == `NCLG_OFF_RSVD_B || s_axi_araddr == `NCLG_OFF_RSVD_C)
      |=> s_axi_rdata == 32'h0000_0000) else $error("reserved register read not zero");
   AST_VER_LAYOUT: assert property (rd_fire && s_axi_araddr == `NCLG_OFF_VERSION // RULE2
      |=> s_axi_rdata[31:5] == 27'h0 && s_axi_rdata[3:0] == $past(info_version_word[3:0]))
      else $error("version word layout wrong");
   AST_DIVLD: assert property (wr_div |=> divider_loaded_flag) // RULE5
      else $error("divider write did not set loaded flag");
   AST_NODIV: assert property (state == NCLG_CHECK && is_pe && !divider_loaded_flag // RULE6
      |=> access_error_flag && command_complete_flag && !cmd_start)
      else $error("program or erase ran without divider");
   AST_LOCK: assert property (!command_complete_flag |=> $stable(arr) || $past(cmd_done)) // RULE8
      else $error("array changed while busy");
   AST_UNIMP: assert property (rd_fire && s_axi_araddr == `NCLG_OFF_PARAM // RULE19
      && parameter_index_field[2:1] == 2'b11 |=> s_axi_rdata == 32'h0000_0000)
      else $error("unimplemented index read not zero");
   AST_LAUNCH: assert property (s_launch |=> !command_complete_flag ##0 // RULE10
      state == NCLG_CHECK) else $error("launch did not clear completion");
   AST_START: assert property (s_check_ok |=> cmd_start && cmd_params == $past(arr) // RULE10
      ##1 !cmd_start) else $error("command not handed over");
   AST_REJECT: assert property (s_check_fail |=> access_error_flag // RULE20
      && command_complete_flag && state == NCLG_IDLE) else $error("bad code not rejected");
   AST_DONE: assert property (state == NCLG_BUSY && cmd_done |=> command_complete_flag // RULE11
      && arr == $past(cmd_result)) else $error("completion or results missing");
   AST_HOLD: assert property (state == NCLG_BUSY && !cmd_done |=> !command_complete_flag) // RULE11
      else $error("completion set early");
   AST_SEC_SS: assert property (state == NCLG_CHECK && mode_q.special && mode_q.secured // RULE14
      && code == NCLG_PROG |=> access_error_flag) else $error("program allowed secured special");
endmodule

/* File: nvm_command_launch_gate_test.sv */
`include "nclg_defs.svh"
module nvm_command_launch_gate_test import nclg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic special_mode_input = 1'b0, secure_input = 1'b0;
   logic [15:0] info_version_word = 16'h0000;
   logic cmd_start, cmd_done = 1'b0, cmd_protection_violation_flag = 1'b0, nvm_time_base;
   nclg_params_t cmd_params, cmd_result = '0;
   int errors = 0, total_checks = 0, starts = 0, ticks = 0, t0 = 0;
   logic [7:0] cap_code = 8'h00;
   logic [7:0] codes [18] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
      8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h05, 8'hFF};
   logic [15:0] vers [4] = '{16'hFFF1, 16'h0000, 16'h000F, 16'h123A};

   always #5 core_clk = ~core_clk;

   nclg_gate dut (.core_clk(core_clk), .reset_n(reset_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .special_mode_input(special_mode_input), .secure_input(secure_input),
      .info_version_word(info_version_word), .cmd_start(cmd_start), .cmd_params(cmd_params),
      .cmd_done(cmd_done), .cmd_result(cmd_result), .cmd_protection_violation_flag(cmd_protection_violation_flag),
      .nvm_time_base(nvm_time_base));

   // launch and time base monitor
   always @(posedge core_clk) begin
      if (cmd_start === 1'b1) begin
         starts <= starts + 1;
         cap_code <= cmd_params.words[0][15:8];
      end
      if (nvm_time_base === 1'b1) ticks <= ticks + 1;
   end

   task automatic stop_test;
      if (errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t response %b expected %b", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = `NCLG_RESP_OKAY);
      bit a_d, w_d, done;
      a_d = 0;
      w_d = 0;
      done = 0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      while (!done) begin
         @(posedge core_clk);
         if (!a_d && s_axi_awready === 1'b1) begin
            a_d = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_d && s_axi_wready === 1'b1) begin
            w_d = 1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid === 1'b1) begin
            done = 1;
            s_axi_bready <= 1'b0;
            check_resp(s_axi_bresp, er);
         end else begin
            s_axi_bready <= 1'b1;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er = `NCLG_RESP_OKAY);
      bit a_d, done;
      a_d = 0;
      done = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while (!done) begin
         @(posedge core_clk);
         if (!a_d && s_axi_arready === 1'b1) begin
            a_d = 1;
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid === 1'b1) begin
            done = 1;
            s_axi_rready <= 1'b0;
            check(s_axi_rdata, exp);
            check_resp(s_axi_rresp, er);
         end else begin
            s_axi_rready <= 1'b1;
         end
      end
   endtask

   function automatic bit cmd_ok(logic [7:0] c, bit sp, bit sec, bit dl);
      if (!dl && c inside {8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h11, 8'h12})
         return 0;
      case (c)
         8'h01, 8'h02: return 1;
         8'h08, 8'h0B: return sp;
         8'h0C: return !sp;
         8'h0E: return sp && !sec;
         8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0D, 8'h10, 8'h11, 8'h12: begin
            return !(sp && sec);
         end
         default: return 0;
      endcase
   endfunction

   task automatic launch(input logic [7:0] c, input bit sp, input bit sec, input bit dl);
      int s0;
      s0 = starts;
      wr(`NCLG_OFF_INDEX, 32'h0000_0000);
      wr(`NCLG_OFF_PARAM, {16'h0000, c, 8'h00});
      wr(`NCLG_OFF_STATUS, 32'h0000_0080);
      cycles(4);
      if (cmd_ok(c, sp, sec, dl)) begin
         check(32'(s0 + 1), 32'(starts));
         check({24'h00_0000, cap_code}, {24'h00_0000, c});
         rd(`NCLG_OFF_STATUS, 32'h0000_0000);
         wr(`NCLG_OFF_PARAM, 32'h0000_FFFF);
         rd(`NCLG_OFF_PARAM, {16'h0000, c, 8'h00});
         wr(`NCLG_OFF_STATUS, 32'h0000_0080);
         cycles(4);
         check(32'(s0 + 1), 32'(starts));
         cmd_result.words[0] <= {8'h5A, c};
         cmd_protection_violation_flag <= (c == 8'h07);
         cmd_done <= 1'b1;
         cycles(1);
         cmd_done <= 1'b0;
         cmd_protection_violation_flag <= 1'b0;
         cycles(2);
         rd(`NCLG_OFF_STATUS, (c == 8'h07) ? 32'h0000_0090 : 32'h0000_0080);
         rd(`NCLG_OFF_PARAM, {16'h0000, 8'h5A, c});
         wr(`NCLG_OFF_STATUS, 32'h0000_0010);
      end else begin
         check(32'(s0), 32'(starts));
         rd(`NCLG_OFF_STATUS, 32'h0000_00A0);
         wr(`NCLG_OFF_STATUS, 32'h0000_0020);
      end
      rd(`NCLG_OFF_STATUS, 32'h0000_0080);
   endtask

   initial begin
      cycles(40000);
      errors++;
      stop_test();
   end

   initial begin
      cycles(10);
      reset_n <= 1'b1;
      cycles(1);
      rd(`NCLG_OFF_STATUS, 32'h0000_0080);
      rd(`NCLG_OFF_CLKDIV, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         wr(8'(`NCLG_OFF_RSVD_A + 4 * i), 32'h0000_00FF);
         rd(8'(`NCLG_OFF_RSVD_A + 4 * i), 32'h0000_0000);
      end
      foreach (vers[i]) begin
         info_version_word <= vers[i];
         cycles(1);
         rd(`NCLG_OFF_VERSION, {27'h0, !(vers[i][3:0] inside {4'h0, 4'hF}), vers[i][3:0]});
      end
      for (int i = 0; i < 8; i++) begin
         wr(`NCLG_OFF_INDEX, 32'(i));
         wr(`NCLG_OFF_PARAM, 32'h0000_A000 + 32'(i));
      end
      for (int i = 0; i < 8; i++) begin
         wr(`NCLG_OFF_INDEX, 32'(i));
         rd(`NCLG_OFF_PARAM, (i < 6) ? 32'h0000_A000 + 32'(i) : 32'h0000_0000);
      end
      wr(8'h40, 32'h0000_0001, `NCLG_RESP_SLVERR);
      rd(8'h40, 32'h0000_0000, `NCLG_RESP_SLVERR);
      check(32'(ticks), 32'h0000_0000);
      for (int dl = 0; dl < 2; dl++) begin
         if (dl == 1) begin
            wr(`NCLG_OFF_CLKDIV, 32'h0000_003F);
            rd(`NCLG_OFF_CLKDIV, 32'h0000_00BF);
            cycles(6);
            t0 = ticks;
            cycles(640);
            check(32'(ticks - t0), 32'h0000_000A);
         end
         for (int m = 0; m < 4; m++) begin
            special_mode_input <= m[1];
            secure_input <= m[0];
            cycles(5);
            foreach (codes[k]) launch(codes[k], m[1], m[0], dl[0]);
         end
      end
      // mid-run reset: divider must read unloaded again
      reset_n <= 1'b0;
      special_mode_input <= 1'b0;
      secure_input <= 1'b0;
      cycles(2);
      reset_n <= 1'b1;
      cycles(1);
      rd(`NCLG_OFF_STATUS, 32'h0000_0080);
      rd(`NCLG_OFF_CLKDIV, 32'h0000_0000);
      launch(8'h06, 1'b0, 1'b0, 1'b0);
      stop_test();
   end
endmodule
